//--- rtl/ppio_top.sv
/*
 * Programmable parallel I/O block: host bus decode, control word, port directions
 * and read multiplexer. Assumes every input is synchronous to refClk; pins are split
 * into input, output and enable, and pad logic resolves the wires.
 */
`timescale 1ns/1ps
module ppio_top (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    // Host bus
    input wire ppio_pkg::ppio_host_s host,
    input wire logic [7:0] sysDataIn,
    output logic [7:0] sysDataOut,
    output logic sysDataOe,
    // Port lines
    input wire logic [7:0] firstPortLinesIn,
    input wire logic [7:0] secondPortLinesIn,
    input wire logic [7:0] thirdPortLinesIn,
    output ppio_pkg::ppio_pins_s firstPortLines,
    output ppio_pkg::ppio_pins_s secondPortLines,
    output ppio_pkg::ppio_pins_s thirdPortLines
);
    import ppio_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic wrAct;
    logic rdAct;
    logic portReset;
    logic commit;
    ppio_state_e state;
    ppio_state_e next_state;
    logic [1:0] capAddr;
    logic [1:0] next_capAddr;
    logic [7:0] capData;
    logic [7:0] next_capData;
    logic [7:0] rdData;
    logic [WORD_COUNT*PORT_W-1:0] words;
    logic [7:0] ctrlWord;
    ppio_mode_e modeA;
    logic [7:0] firstOe;
    logic [7:0] secondOe;
    logic [7:0] thirdOe;
    logic [7:0] next_firstOe;
    logic [7:0] next_secondOe;
    logic [7:0] next_thirdOe;
    logic [7:0] next_sysDataOut;
    logic next_sysDataOe;

    // A pin read returns the latch where driven and the line where released.
    function automatic logic [7:0] readBack(input logic [7:0] latch, input logic [7:0] oe,
                                            input logic [7:0] pins);
        readBack = (latch & oe) | (pins & ~oe);
    endfunction

    // ************************************************************
    // Host strobe decode
    // ************************************************************
    // Nothing is decoded unless select is low; a write beats a read on a bus clash.
    assign wrAct = !host.selectN && !host.writeStrobeN; // R12 R05
    assign rdAct = !host.selectN && !host.readStrobeN && host.writeStrobeN; // R12
    // Ports drop while the control write strobe is still low, not at its end.
    assign portReset = wrAct && (host.addr == ADDR_CONTROL); // R10
    // The first release of strobe or select ends the access and commits it.
    assign commit = (state == ST_WRITE) && !wrAct; // R09

    // ************************************************************
    // Access sequencer
    // ************************************************************
    // Address is re-sampled every active cycle and data every write cycle, so the last sample wins.
    always_comb begin
        next_state = state;
        next_capAddr = capAddr;
        next_capData = capData;
        if (wrAct) begin
            next_capAddr = host.addr;
            next_capData = sysDataIn; // R09
        end else if (rdAct) begin
            next_capAddr = host.addr;
        end
        case (state)
            ST_IDLE: begin
                if (wrAct) begin
                    next_state = ST_WRITE;
                end else if (rdAct) begin
                    next_state = ST_READ;
                end
            end
            // A strobe swap with no idle cycle between goes straight to the other
            // access, so a write still commits and a read keeps its two-cycle answer.
            ST_WRITE: begin
                if (rdAct) begin
                    next_state = ST_READ;
                end else if (!wrAct) begin
                    next_state = ST_IDLE;
                end
            end
            ST_READ: begin
                if (wrAct) begin
                    next_state = ST_WRITE;
                end else if (!rdAct) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= ST_IDLE;
            capAddr <= ADDR_FIRST;
            capData <= LINES_OFF;
        end else if (clkEn) begin
            state <= next_state;
            capAddr <= next_capAddr;
            capData <= next_capData;
        end
    end

    // ************************************************************
    // Port latches and control word storage
    // ************************************************************
    // The control word sits as the top word so it reads back like a port.
    ppio_latch_bank #(
        .WIDTH(PORT_W),
        .DEPTH(WORD_COUNT),
        .TOP_RESET(CTRL_RESET)
    ) u_latches (
        .clk(ref_clk),
        .reset(reset),
        .clkEn(clkEn),
        .wrEn(commit),
        .wrAddr(capAddr),
        .wrData(capData),
        .clearPorts(portReset),
        .rdAddr(host.addr),
        .rdData(rdData),
        .words(words)
    );

    assign ctrlWord = words[ADDR_CONTROL*PORT_W +: PORT_W]; // R07 R08
    assign modeA = groupAMode(ctrlWord); // R02

    // ************************************************************
    // Port direction
    // ************************************************************
    // Each group of twelve lines turns with its own control bits. Strobed mode
    // uses the same direction as basic mode; bidirectional mode turns the first
    // port around while the host reads it. Lines released here float: there is
    // no internal pull or hold.
    always_comb begin
        next_firstOe = lineEnable(ctrlWord[CW_A_IN]); // R03 R01
        next_secondOe = lineEnable(ctrlWord[CW_B_IN]); // R04 R01
        next_thirdOe = {{4{!ctrlWord[CW_CU_IN]}}, {4{!ctrlWord[CW_CL_IN]}}}; // R03 R04 R11
        if (modeA == MODE_BIDIR) begin
            next_firstOe = (rdAct && host.addr == ADDR_FIRST) ? LINES_OFF : LINES_ON; // R02
        end
        if (portReset) begin
            next_firstOe = LINES_OFF; // R10
            next_secondOe = LINES_OFF;
            next_thirdOe = LINES_OFF;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            firstOe <= LINES_OFF;
            secondOe <= LINES_OFF;
            thirdOe <= LINES_OFF;
        end else if (clkEn) begin
            firstOe <= next_firstOe;
            secondOe <= next_secondOe;
            thirdOe <= next_thirdOe;
        end
    end

    assign firstPortLines.out = words[ADDR_FIRST*PORT_W +: PORT_W];
    assign firstPortLines.oe = firstOe;
    assign secondPortLines.out = words[ADDR_SECOND*PORT_W +: PORT_W];
    assign secondPortLines.oe = secondOe;
    assign thirdPortLines.out = words[ADDR_THIRD*PORT_W +: PORT_W];
    assign thirdPortLines.oe = thirdOe;

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    // Latched read data trails the address by a cycle, so the bus is driven from
    // the third read cycle on; this costs a cycle but keeps outputs registered.
    always_comb begin
        next_sysDataOe = (state == ST_READ) && rdAct; // R06
        next_sysDataOut = sysDataOut;
        if (next_sysDataOe) begin
            if (capAddr == ADDR_FIRST) begin
                next_sysDataOut = readBack(rdData, firstOe, firstPortLinesIn); // R06
            end else if (capAddr == ADDR_SECOND) begin
                next_sysDataOut = readBack(rdData, secondOe, secondPortLinesIn);
            end else if (capAddr == ADDR_THIRD) begin
                next_sysDataOut = readBack(rdData, thirdOe, thirdPortLinesIn);
            end else begin
                next_sysDataOut = rdData; // R08
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sysDataOut <= LINES_OFF;
            sysDataOe <= 1'b0;
        end else if (clkEn) begin
            sysDataOut <= next_sysDataOut;
            sysDataOe <= next_sysDataOe;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_cw_reset;
        @(posedge ref_clk) disable iff (reset) $fell(reset) |-> ctrlWord == 8'h9B;
    endproperty
    a_cw_reset: assert property (p_cw_reset) else $error("control word not 9B after reset"); // R08

    property p_ctrl_write_reset;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && wrAct && host.addr == ADDR_CONTROL)
            |=> (firstOe == 8'h00 && secondOe == 8'h00 && thirdOe == 8'h00
                 && words[23:0] == 24'h000000);
    endproperty
    a_ctrl_write_reset: assert property (p_ctrl_write_reset) else $error("ports not reset"); // R10

    property p_commit_cw;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && state == ST_WRITE && !wrAct && capAddr == ADDR_CONTROL)
            |=> ctrlWord == $past(capData);
    endproperty
    a_commit_cw: assert property (p_commit_cw) else $error("control word not captured"); // R09

    property p_commit_port;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && state == ST_WRITE && !wrAct && capAddr == ADDR_SECOND)
            |=> secondPortLines.out == $past(capData);
    endproperty
    a_commit_port: assert property (p_commit_port) else $error("port latch not captured"); // R09

    property p_read_drive;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && rdAct) ##1 (clkEn && rdAct) |=> sysDataOe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven"); // R06

    property p_select_gate;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && host.selectN) |=> !sysDataOe;
    endproperty
    a_select_gate: assert property (p_select_gate) else $error("bus driven unselected"); // R12

    property p_group_a;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && !portReset && modeA != MODE_BIDIR)
            |=> firstOe == {8{!$past(ctrlWord[CW_A_IN])}}
                && thirdOe[7:4] == {4{!$past(ctrlWord[CW_CU_IN])}};
    endproperty
    a_group_a: assert property (p_group_a) else $error("group A direction wrong"); // R03

    property p_group_b;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && !portReset)
            |=> secondOe == {8{!$past(ctrlWord[CW_B_IN])}}
                && thirdOe[3:0] == {4{!$past(ctrlWord[CW_CL_IN])}};
    endproperty
    a_group_b: assert property (p_group_b) else $error("group B direction wrong"); // R04

    property p_cw_readback;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && state == ST_READ && rdAct && capAddr == ADDR_CONTROL && !commit)
            |=> sysDataOut == $past(rdData);
    endproperty
    a_cw_readback: assert property (p_cw_readback) else $error("control readback wrong"); // R08

    property p_bidir_turn;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && !portReset && modeA == MODE_BIDIR)
            |=> firstOe == (($past(rdAct) && $past(host.addr) == ADDR_FIRST) ? 8'h00 : 8'hFF);
    endproperty
    a_bidir_turn: assert property (p_bidir_turn) else $error("bidirectional turn wrong"); // R02

    property p_read_release;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && !rdAct) |=> !sysDataOe;
    endproperty
    a_read_release: assert property (p_read_release) else $error("bus held after read"); // R06

    property p_idle_hold;
        @(posedge ref_clk) disable iff (reset)
            (clkEn && host.selectN && state == ST_IDLE) |=> words == $past(words);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("latch changed unselected"); // R12

endmodule // ppio_top

//--- rtl/ppio_pkg.sv
/*
 * Shared constants, types and helper functions of the programmable parallel I/O block.
 * Assumes a single 100 MHz clock and a host bus that is synchronous to that clock.
 */
// What this block does
// R01: Twenty-four lines in two groups of twelve.
// R02: Basic, strobed and bidirectional modes from control.
// R03: First port plus upper third nibble together.
// R04: Second port plus lower third nibble together.
// R05: Byte data bus, two-bit address, low strobes.
// R06: Reads multiplex the selected port onto bus.
// R07: One control word holds all port programming.
// R08: Control word readable, resets to hex 9B.
// R09: Write captured at first strobe or select release.
// R10: Control write resets ports while strobe low.
// R11: No pull or bus-hold on port lines.
// R12: Addresses zero-two select ports, three control.
// R13: Host programs control once before using ports.
package ppio_pkg;

    // ************************************************************
    // Sizes, addresses and reset values
    // ************************************************************
    localparam int PORT_W = 8;
    localparam int WORD_COUNT = 4;
    localparam logic [1:0] ADDR_FIRST = 2'h0;
    localparam logic [1:0] ADDR_SECOND = 2'h1;
    localparam logic [1:0] ADDR_THIRD = 2'h2;
    localparam logic [1:0] ADDR_CONTROL = 2'h3;
    localparam logic [7:0] CTRL_RESET = 8'h9B;
    localparam logic [7:0] LINES_OFF = 8'h00;
    localparam logic [7:0] LINES_ON = 8'hFF;

    // ************************************************************
    // Control word field positions
    // ************************************************************
    localparam int CW_MODE_SET = 7;
    localparam int CW_A_MODE_HI = 6;
    localparam int CW_A_MODE_LO = 5;
    localparam int CW_A_IN = 4;
    localparam int CW_CU_IN = 3;
    localparam int CW_B_MODE = 2;
    localparam int CW_B_IN = 1;
    localparam int CW_CL_IN = 0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {MODE_BASIC, MODE_STROBED, MODE_BIDIR} ppio_mode_e;
    typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} ppio_state_e;

    typedef struct packed {
        logic [1:0] addr;
        logic readStrobeN;
        logic writeStrobeN;
        logic selectN;
    } ppio_host_s;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } ppio_pins_s;

    // ************************************************************
    // Functions
    // ************************************************************
    // An input bit of one means the group's lines are released.
    function automatic logic [7:0] lineEnable(input logic isInput);
        lineEnable = isInput ? LINES_OFF : LINES_ON;
    endfunction

    // Group A mode: 00 basic, 01 strobed, 1x bidirectional.
    function automatic ppio_mode_e groupAMode(input logic [7:0] cw);
        if (cw[CW_A_MODE_HI]) begin
            groupAMode = MODE_BIDIR;
        end else if (cw[CW_A_MODE_LO]) begin
            groupAMode = MODE_STROBED;
        end else begin
            groupAMode = MODE_BASIC;
        end
    endfunction

endpackage

//--- rtl/ppio_latch_bank.sv
/*
 * Output latches of the three ports plus the control word, with a registered read port.
 * Assumes writes arrive as one-cycle pulses and the top word is the control word.
 */
`timescale 1ns/1ps
module ppio_latch_bank #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter logic [WIDTH-1:0] TOP_RESET = '0
) (
    // Clock and control
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    // Write side
    input wire logic wrEn,
    input wire logic [$clog2(DEPTH)-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic clearPorts,
    // Read side
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData,
    output logic [DEPTH*WIDTH-1:0] words
);

    logic [DEPTH*WIDTH-1:0] next_words;
    logic [WIDTH-1:0] next_rdData;

    // Port latches clear on request; the top word is never cleared.
    always_comb begin
        next_words = words;
        if (clearPorts) begin
            next_words[(DEPTH-1)*WIDTH-1:0] = '0;
        end
        if (wrEn) begin
            next_words[wrAddr*WIDTH +: WIDTH] = wrData;
        end
        next_rdData = words[rdAddr*WIDTH +: WIDTH];
    end

    // Registered storage and read data.
    always_ff @(posedge clk) begin
        if (reset) begin
            words <= {TOP_RESET, {((DEPTH-1)*WIDTH){1'b0}}};
            rdData <= '0;
        end else if (clkEn) begin
            words <= next_words;
            rdData <= next_rdData;
        end
    end

endmodule // ppio_latch_bank

//--- test/ppio_host_model.sv
/*
 * Host bus model: byte writes and reads on the strobed bus of the parallel I/O block.
 * Assumes the bench resolves the shared data wire from sysDataOe and calls the tasks.
 */
`timescale 1ns/1ps
module ppio_host_model (
    // Clock
    input wire logic ref_clk,
    // Device answer
    input wire logic sysDataOe,
    input wire logic [7:0] sysDataOut,
    // Bus drive
    output ppio_pkg::ppio_host_s host,
    output logic [7:0] hostData
);
    import ppio_pkg::*;

    // ************************************************************
    // Idle bus
    // ************************************************************
    // Nothing selected at time zero; the stored byte is inverted on release.
    initial begin
        host = '{addr: 2'h0, readStrobeN: 1'b1, writeStrobeN: 1'b1, selectN: 1'b1};
        hostData = 8'h00;
    end

    // ************************************************************
    // Transfers
    // ************************************************************
    // Mode 0 ends with the strobe, 1 with the select, 2 never selects the device.
    task automatic busWrite(input logic [1:0] a, input logic [7:0] d, input int hold,
                            input int mode);
        @(negedge ref_clk);
        host.addr = a;
        hostData = d;
        host.selectN = (mode == 2);
        host.writeStrobeN = 1'b0;
        repeat (hold) @(negedge ref_clk);
        if (mode == 1) begin
            host.selectN = 1'b1;
        end else begin
            host.writeStrobeN = 1'b1;
        end
        // Stale data after release, so a late capture shows up.
        hostData = ~d;
        @(negedge ref_clk);
        host.selectN = 1'b1;
        host.writeStrobeN = 1'b1;
        @(negedge ref_clk);
    endtask

    // Holds the address until the device drives, bounded so a hang cannot stall.
    task automatic busRead(input logic [1:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge ref_clk);
        host.addr = a;
        host.selectN = 1'b0;
        host.readStrobeN = 1'b0;
        hostData = ~hostData;
        while (sysDataOe !== 1'b1 && n < 8) begin
            @(negedge ref_clk);
            n++;
        end
        d = (n < 8) ? sysDataOut : 8'hXX;
        host.selectN = 1'b1;
        host.readStrobeN = 1'b1;
        @(negedge ref_clk);
        @(negedge ref_clk);
    endtask
endmodule // ppio_host_model

//--- test/test_programmable_parallel_io.sv
/*
 * Self-checking bench of the parallel I/O block with a host bus model.
 * Assumes pads without pulls: a released line shows what the far side drives.
 */
`timescale 1ns/1ps
module test_programmable_parallel_io;
    import ppio_pkg::*;

    // ************************************************************
    // Signals
    // ************************************************************
    logic ref_clk;
    logic reset;
    ppio_host_s host;
    logic [7:0] hostData;
    logic [7:0] sysDataIn;
    logic [7:0] sysDataOut;
    logic sysDataOe;
    logic [7:0] farDrive;
    logic [7:0] firstIn;
    logic [7:0] secondIn;
    logic [7:0] thirdIn;
    ppio_pins_s firstPortLines;
    ppio_pins_s secondPortLines;
    ppio_pins_s thirdPortLines;
    int errorCnt;
    int compares;
    logic [7:0] rd;

    // Wire levels from every driver; no pull on the port lines.
    assign sysDataIn = sysDataOe ? sysDataOut : hostData;
    assign firstIn = (firstPortLines.oe & firstPortLines.out)
        | (~firstPortLines.oe & farDrive);
    assign secondIn = (secondPortLines.oe & secondPortLines.out)
        | (~secondPortLines.oe & farDrive);
    assign thirdIn = (thirdPortLines.oe & thirdPortLines.out)
        | (~thirdPortLines.oe & farDrive);

    ppio_host_model hostBus (.ref_clk(ref_clk), .sysDataOe(sysDataOe), .sysDataOut(sysDataOut),
        .host(host), .hostData(hostData));

    ppio_top uut (.ref_clk(ref_clk), .reset(reset), .clkEn(1'b1), .host(host),
        .sysDataIn(sysDataIn), .sysDataOut(sysDataOut), .sysDataOe(sysDataOe),
        .firstPortLinesIn(firstIn), .secondPortLinesIn(secondIn), .thirdPortLinesIn(thirdIn),
        .firstPortLines(firstPortLines), .secondPortLines(secondPortLines),
        .thirdPortLines(thirdPortLines));

    // ************************************************************
    // Helpers
    // ************************************************************
    // Clock of 10 ns.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic printVerdict();
        $display("Comparisons %0d, mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset leaves every line released and the control word at its reset value.
    task automatic tReset();
        check("first oe", firstPortLines.oe, 8'h00);
        check("third out", thirdPortLines.out, 8'h00);
        hostBus.busRead(ADDR_CONTROL, rd);
        check("control reset", rd, CTRL_RESET);
    endtask

    // Every group setting and mode; directions follow the stored word.
    task automatic tGroups();
        logic [7:0] cws [6];
        cws = '{8'h80, 8'h91, 8'h8A, 8'h9B, 8'hA0, 8'hC0};
        foreach (cws[i]) begin
            hostBus.busWrite(ADDR_CONTROL, cws[i], 1, 0);
            @(negedge ref_clk);
            check("first oe", firstPortLines.oe, cws[i][4] ? 8'h00 : 8'hFF);
            check("second oe", secondPortLines.oe, cws[i][1] ? 8'h00 : 8'hFF);
            check("third oe", thirdPortLines.oe,
                {cws[i][3] ? 4'h0 : 4'hF, cws[i][0] ? 4'h0 : 4'hF});
            hostBus.busRead(ADDR_CONTROL, rd);
            check("control read", rd, cws[i]);
        end
    endtask

    // Latches, readback and mixed halves of the third port.
    task automatic tPorts();
        hostBus.busWrite(ADDR_CONTROL, 8'h80, 1, 0);
        hostBus.busWrite(ADDR_FIRST, 8'h5A, 1, 0);
        hostBus.busWrite(ADDR_SECOND, 8'hC3, 2, 0);
        hostBus.busWrite(ADDR_THIRD, 8'h96, 1, 0);
        check("first out", firstPortLines.out, 8'h5A);
        check("second out", secondPortLines.out, 8'hC3);
        check("third out", thirdPortLines.out, 8'h96);
        hostBus.busRead(ADDR_SECOND, rd);
        check("second read", rd, 8'hC3);
        hostBus.busRead(ADDR_THIRD, rd);
        check("third read", rd, 8'h96);
        farDrive = 8'h3C;
        hostBus.busWrite(ADDR_CONTROL, 8'h91, 1, 0);
        hostBus.busWrite(ADDR_THIRD, 8'hA5, 1, 0);
        hostBus.busRead(ADDR_THIRD, rd);
        check("third mixed", rd, 8'hAC);
        hostBus.busRead(ADDR_FIRST, rd);
        check("first pads", rd, 8'h3C);
    endtask

    // A control write clears ports while its strobe is still low.
    task automatic tCtrlReset();
        hostBus.busWrite(ADDR_CONTROL, 8'h80, 1, 0);
        hostBus.busWrite(ADDR_FIRST, 8'h5A, 1, 0);
        fork
            hostBus.busWrite(ADDR_CONTROL, 8'h80, 4, 0);
            begin
                repeat (4) @(negedge ref_clk);
                check("oe during control", firstPortLines.oe, 8'h00);
                check("out during control", firstPortLines.out, 8'h00);
            end
        join
        check("out after control", firstPortLines.out, 8'h00);
    endtask

    // Select released first takes the data then; an unselected write is ignored.
    task automatic tCapture();
        hostBus.busWrite(ADDR_FIRST, 8'h3C, 2, 1);
        check("select release", firstPortLines.out, 8'h3C);
        hostBus.busWrite(ADDR_FIRST, 8'hFF, 2, 2);
        check("unselected", firstPortLines.out, 8'h3C);
    endtask

    // Bidirectional first port is released only while the host reads it.
    task automatic tBidir();
        hostBus.busWrite(ADDR_CONTROL, 8'hC0, 1, 0);
        hostBus.busWrite(ADDR_FIRST, 8'h77, 1, 0);
        farDrive = 8'h69;
        check("bidir drive", firstPortLines.oe, 8'hFF);
        hostBus.busRead(ADDR_FIRST, rd);
        check("bidir read", rd, 8'h69);
        check("bidir restore", firstPortLines.oe, 8'hFF);
        check("bus released", {7'h00, sysDataOe}, 8'h00);
        check("third cleared", thirdPortLines.out, 8'h00);
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        errorCnt = 0;
        compares = 0;
        farDrive = 8'h00;
        reset = 1'b1;
        repeat (20) @(negedge ref_clk);
        reset = 1'b0;
        tReset();
        tGroups();
        tPorts();
        tCtrlReset();
        tCapture();
        tBidir();
        printVerdict();
    end

    // The tests need well under a thousand cycles; this is many times that.
    initial begin
        #100us;
        errorCnt++;
        printVerdict();
    end
endmodule // test_programmable_parallel_io
